/* File: pkg/flash_ctrl_pkg.sv */
/*
 flash_ctrl_pkg: command codes, unlock addresses, bus timing and status bit
 positions for the host-side controller of a parallel NOR flash.
 Assumes word-mode addressing on the flash bus.
*/
package flash_ctrl_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;

	localparam logic [20:0] UNLOCK_ADDR1 = 21'h000555;
	localparam logic [20:0] UNLOCK_ADDR2 = 21'h0002AA;
	localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;

	localparam logic [7:0] CMD_PROGRAM   = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SET = 8'h80;
	localparam logic [7:0] CMD_SUSPEND   = 8'hB0;
	localparam logic [7:0] CMD_RESET     = 8'hF0;
	localparam logic [7:0] CMD_AUTOSEL   = 8'h90;
	localparam logic [7:0] CMD_CHIP_ERS  = 8'h10;
	localparam logic [7:0] CMD_SECT_ERS  = 8'h30;

	localparam int SECTOR_LSB = 12;

	localparam int POLL_BIT    = 7;
	localparam int TOGGLE_BIT  = 6;
	localparam int TIMEOUT_BIT = 5;

	localparam int CLK_MHZ       = 200;
	localparam int WRITE_PULSE_NS = 50;
	localparam int READ_ACCESS_NS = 70;
	localparam int SUSPEND_MAX_US = 20;
	localparam logic [7:0] WRITE_PULSE_CYC = 8'((WRITE_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] READ_ACCESS_CYC = 8'((READ_ACCESS_NS * CLK_MHZ + 999) / 1000);
	localparam int SUSPEND_CYC = SUSPEND_MAX_US * CLK_MHZ;

	localparam logic [3:0] OP_RESET     = 4'h0;
	localparam logic [3:0] OP_AUTOSEL   = 4'h1;
	localparam logic [3:0] OP_PROGRAM   = 4'h2;
	localparam logic [3:0] OP_CHIP_ERS  = 4'h3;
	localparam logic [3:0] OP_SECT_ERS  = 4'h4;
	localparam logic [3:0] OP_SUSPEND   = 4'h5;
	localparam logic [3:0] OP_RESUME    = 4'h6;
	localparam logic [3:0] OP_READ      = 4'h7;
endpackage

/* File: rtl/flash_bus_cycle.sv */
/*
 flash_bus_cycle: one asynchronous write or read cycle on the flash pins.
 Assumes the flash is an asynchronous device sampled through two flops.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
	import flash_ctrl_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              start,
	input  wire logic              is_write,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [DATA_W-1:0] dq_in,
	output logic                   done,
	output logic [DATA_W-1:0]      rdata,
	output logic                   ce_n,
	output logic                   we_n,
	output logic                   oe_n,
	output logic [ADDR_W-1:0]      a_out,
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe
);
	typedef enum logic [1:0] {IDLE = 2'b00, SETUP = 2'b01, PULSE = 2'b11, HOLD = 2'b10} cyc_e;
	cyc_e                   st_r, st_nxt;
	logic [7:0]             cnt_r, cnt_nxt;
	logic                   wr_r, wr_nxt;
	logic [DATA_W-1:0]      sync1_r, sync2_r;
	logic [DATA_W-1:0]      rdata_nxt;
	logic [ADDR_W-1:0]      a_nxt;
	logic [DATA_W-1:0]      dq_nxt;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= dq_in;
			sync2_r <= sync1_r;
		end
	end

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		rdata_nxt = rdata;
		a_nxt = a_out;
		dq_nxt = dq_out;
		case (st_r)
			IDLE: begin
				if (start) begin
					st_nxt = SETUP;
					wr_nxt = is_write;
					a_nxt = addr;
					dq_nxt = wdata;
				end
			end
			SETUP: begin
				st_nxt = PULSE;
				cnt_nxt = wr_r ? WRITE_PULSE_CYC : READ_ACCESS_CYC + 8'h02;
			end
			PULSE: begin
				if (cnt_r == 8'h00) begin
					st_nxt = HOLD;
					if (!wr_r)
						rdata_nxt = sync2_r;
				end else
					cnt_nxt = cnt_r - 8'h01;
			end
			HOLD: st_nxt = IDLE;
			default: st_nxt = IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			rdata <= '0;
			a_out <= '0;
			dq_out <= '0;
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			dq_oe <= 1'b0;
			done <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			rdata <= rdata_nxt;
			a_out <= a_nxt;
			dq_out <= dq_nxt;
			// address settles before strobes fall, data held past their rise
			ce_n <= !(st_nxt == PULSE);
			we_n <= !(st_nxt == PULSE && wr_nxt);
			oe_n <= !(st_nxt == PULSE && !wr_nxt);
			dq_oe <= (st_nxt != IDLE) && wr_nxt;
			done <= (st_r == HOLD);
		end
	end
endmodule
`default_nettype wire

/* File: rtl/flash_cmd_host.sv */
/*
 flash_cmd_host: host controller that issues command sequences to a NOR
 flash, polls completion and recovers from timeouts.
 Assumes a user port giving an opcode with address and data, one at a time.
*/
//Contract
//- every sequence opens with AA to 555 then 55 to 2AA; suspend, resume and reset are sent here as one write with no unlock
//- leaving identification mode requires a reset write from host
//- program is four writes: two unlocks, A0, address with data
//- chip erase is six writes ending with 10
//- sector erase is six writes ending with sector address and 30
//- one sector per sequence, next only after completion; the host still accepts a new erase request while a sector erase is suspended
//- resume written once, leaves suspend
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_host
	import flash_ctrl_pkg::*;
#(
	parameter int SUSPEND_WAIT = SUSPEND_CYC
)(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              req,
	input  wire logic [3:0]        op,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_data,
	input  wire logic              byte_mode,
	input  wire logic [DATA_W-1:0] dq_in,
	output logic                   busy,
	output logic                   ack,
	output logic                   fail,
	output logic [DATA_W-1:0]      rd_data,
	output logic                   suspended,
	output logic                   ce_n,
	output logic                   we_n,
	output logic                   oe_n,
	output logic                   byte_n,
	output logic [ADDR_W-1:0]      a_out,
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe
);
	typedef enum logic [2:0] {S_IDLE = 3'b000, S_WRITE = 3'b001, S_POLL1 = 3'b011,
		S_POLL2 = 3'b010, S_RESET = 3'b110, S_WAIT = 3'b111, S_READ = 3'b101} st_e;

	st_e                   st_r, st_nxt;
	logic [2:0]            step_r, step_nxt, nsteps_r, nsteps_nxt;
	logic [3:0]            op_r, op_nxt;
	logic [ADDR_W-1:0]     addr_r, addr_nxt;
	logic [DATA_W-1:0]     data_r, data_nxt, prev_r, prev_nxt;
	logic                  fail_r, fail_nxt, ack_nxt, susp_nxt, autosel_r, autosel_nxt;
	logic                  serase_r, serase_nxt;
	logic [31:0]           wait_r, wait_nxt;
	logic                  cyc_start, cyc_wr, cyc_done;
	logic [ADDR_W-1:0]     cyc_addr;
	logic [DATA_W-1:0]     cyc_wdata, cyc_rdata;

	function automatic logic [ADDR_W+7:0] seq_word(input logic [3:0] o, input logic [2:0] s,
		input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [ADDR_W+7:0] w;
		w = {UNLOCK_ADDR1, CMD_RESET};
		case (s)
			3'd0: w = {UNLOCK_ADDR1, UNLOCK_DATA1};
			3'd1: w = {UNLOCK_ADDR2, UNLOCK_DATA2};
			3'd2: w = {UNLOCK_ADDR1, (o == OP_PROGRAM) ? CMD_PROGRAM :
				(o == OP_AUTOSEL) ? CMD_AUTOSEL : CMD_ERASE_SET};
			3'd3: w = (o == OP_PROGRAM) ? {a, d} : {UNLOCK_ADDR1, UNLOCK_DATA1};
			3'd4: w = {UNLOCK_ADDR2, UNLOCK_DATA2};
			3'd5: w = (o == OP_CHIP_ERS) ? {UNLOCK_ADDR1, CMD_CHIP_ERS} :
				{a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}, CMD_SECT_ERS};
			default: w = {UNLOCK_ADDR1, CMD_RESET};
		endcase
		return w;
	endfunction

	always_comb begin
		logic [ADDR_W+7:0] w;
		w = seq_word(op_r, step_r, addr_r, data_r[7:0]);
		cyc_start = 1'b0;
		cyc_wr = 1'b1;
		cyc_addr = w[ADDR_W+7:8];
		cyc_wdata = {8'h00, w[7:0]};
		if (op_r == OP_PROGRAM && step_r == 3'd3)
			cyc_wdata = data_r;
		st_nxt = st_r;
		step_nxt = step_r;
		nsteps_nxt = nsteps_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		prev_nxt = prev_r;
		fail_nxt = fail_r;
		ack_nxt = 1'b0;
		susp_nxt = suspended;
		autosel_nxt = autosel_r;
		serase_nxt = serase_r;
		wait_nxt = wait_r;
		case (st_r)
			S_IDLE: begin
				if (req) begin
					op_nxt = op;
					addr_nxt = req_addr;
					data_nxt = req_data;
					step_nxt = 3'd0;
					fail_nxt = 1'b0;
					st_nxt = S_WRITE;
					case (op)
						OP_PROGRAM: nsteps_nxt = 3'd4;
						OP_AUTOSEL: begin
							nsteps_nxt = 3'd3;
							if (suspended) begin
								st_nxt = S_IDLE;
								ack_nxt = 1'b1;
								fail_nxt = 1'b1;
							end
						end
						OP_CHIP_ERS, OP_SECT_ERS: nsteps_nxt = 3'd6;
						OP_SUSPEND, OP_RESUME, OP_RESET: begin
							nsteps_nxt = 3'd1;
							step_nxt = 3'd6;
						end
						OP_READ: st_nxt = S_READ;
						default: begin
							st_nxt = S_IDLE;
							ack_nxt = 1'b1;
							fail_nxt = 1'b1;
						end
					endcase
					if ((op == OP_SUSPEND && (!serase_r || suspended)) || (op == OP_RESUME && !suspended)) begin
						st_nxt = S_IDLE;
						ack_nxt = 1'b1;
						fail_nxt = 1'b1;
					end
				end
			end
			S_WRITE: begin
				cyc_start = 1'b1;
				if (op_r == OP_SUSPEND || op_r == OP_RESUME)
					cyc_wdata = {8'h00, (op_r == OP_SUSPEND) ? CMD_SUSPEND : CMD_SECT_ERS};
				if (cyc_done) begin
					cyc_start = 1'b0;
					step_nxt = step_r + 3'd1;
					if (step_r == 3'd6 || step_r + 3'd1 == nsteps_r) begin
						case (op_r)
							OP_PROGRAM, OP_CHIP_ERS, OP_SECT_ERS: st_nxt = S_POLL1;
							OP_SUSPEND: begin
								st_nxt = S_WAIT;
								wait_nxt = 32'(SUSPEND_WAIT);
							end
							OP_RESUME: begin
								susp_nxt = 1'b0;
								st_nxt = S_POLL1;
								op_nxt = OP_SECT_ERS;
							end
							default: begin
								autosel_nxt = (op_r == OP_AUTOSEL);
								st_nxt = S_IDLE;
								ack_nxt = 1'b1;
							end
						endcase
						if (op_r == OP_SECT_ERS)
							serase_nxt = 1'b1;
					end
				end
			end
			S_POLL1, S_POLL2: begin
				cyc_start = 1'b1;
				cyc_wr = 1'b0;
				cyc_addr = addr_r;
				if (cyc_done) begin
					cyc_start = 1'b0;
					prev_nxt = cyc_rdata;
					st_nxt = S_POLL2;
					if (st_r == S_POLL2 && cyc_rdata[TOGGLE_BIT] == prev_r[TOGGLE_BIT]) begin
						st_nxt = S_IDLE;
						ack_nxt = 1'b1;
						serase_nxt = serase_r && suspended;
						if (op_r == OP_SECT_ERS)
							serase_nxt = 1'b0;
					end else if (st_r == S_POLL2 && prev_r[TIMEOUT_BIT] && cyc_rdata[TIMEOUT_BIT]) begin
						fail_nxt = 1'b1;
						st_nxt = S_RESET;
					end else if (req && op == OP_SUSPEND && serase_r && op_r == OP_SECT_ERS) begin
						op_nxt = OP_SUSPEND;
						step_nxt = 3'd6;
						nsteps_nxt = 3'd1;
						st_nxt = S_WRITE;
					end
				end
			end
			S_RESET: begin
				cyc_start = 1'b1;
				cyc_wdata = {8'h00, CMD_RESET};
				if (cyc_done) begin
					cyc_start = 1'b0;
					st_nxt = S_IDLE;
					ack_nxt = 1'b1;
					serase_nxt = 1'b0;
					susp_nxt = 1'b0;
				end
			end
			S_WAIT: begin
				if (wait_r == 32'h00000000) begin
					susp_nxt = 1'b1;
					st_nxt = S_IDLE;
					ack_nxt = 1'b1;
				end else
					wait_nxt = wait_r - 32'h00000001;
			end
			S_READ: begin
				cyc_start = 1'b1;
				cyc_wr = 1'b0;
				cyc_addr = addr_r;
				if (cyc_done) begin
					cyc_start = 1'b0;
					data_nxt = cyc_rdata;
					st_nxt = S_IDLE;
					ack_nxt = 1'b1;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
		if (op_r == OP_RESET && st_r == S_WRITE && cyc_done)
			autosel_nxt = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= S_IDLE;
			step_r <= 3'd0;
			nsteps_r <= 3'd0;
			op_r <= OP_RESET;
			addr_r <= '0;
			data_r <= '0;
			prev_r <= '0;
			fail_r <= 1'b0;
			autosel_r <= 1'b0;
			serase_r <= 1'b0;
			wait_r <= 32'h00000000;
			ack <= 1'b0;
			suspended <= 1'b0;
			busy <= 1'b0;
			fail <= 1'b0;
			rd_data <= '0;
			byte_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
			step_r <= step_nxt;
			nsteps_r <= nsteps_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			prev_r <= prev_nxt;
			fail_r <= fail_nxt;
			autosel_r <= autosel_nxt;
			serase_r <= serase_nxt;
			wait_r <= wait_nxt;
			ack <= ack_nxt;
			suspended <= susp_nxt;
			busy <= (st_nxt != S_IDLE);
			fail <= fail_nxt;
			rd_data <= data_nxt;
			byte_n <= !byte_mode;
		end
	end

	flash_bus_cycle u_cyc (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.start   (cyc_start),
		.is_write(cyc_wr),
		.addr    (cyc_addr),
		.wdata   (cyc_wdata),
		.dq_in   (dq_in),
		.done    (cyc_done),
		.rdata   (cyc_rdata),
		.ce_n    (ce_n),
		.we_n    (we_n),
		.oe_n    (oe_n),
		.a_out   (a_out),
		.dq_out  (dq_out),
		.dq_oe   (dq_oe)
	);

	unlock_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == S_WRITE && step_r == 3'd0 && cyc_start) |-> cyc_addr == UNLOCK_ADDR1)
		else $error("first write not to unlock address");
	strobe_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(we_n) |-> $stable(a_out) && dq_oe)
		else $error("address or data not set at strobe fall");
	no_cmd_prog_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		((st_r == S_POLL1 || st_r == S_POLL2) && op_r == OP_PROGRAM) |-> we_n)
		else $error("write during program");
	autosel_susp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == S_IDLE && req && op == OP_AUTOSEL && suspended) |=> ack && fail)
		else $error("autoselect taken while suspended");
	suspend_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == S_IDLE && req && op == OP_SUSPEND && (!serase_r || suspended)) |=> st_r == S_IDLE)
		else $error("suspend outside sector erase");
	timeout_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == S_POLL2 && st_nxt == S_RESET) |=> fail_r)
		else $error("timeout without failure flag");
	resume_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st_r == S_WRITE && op_r == OP_RESUME && cyc_done) |=> !suspended)
		else $error("resume left device suspended");
	width_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> byte_n == !$past(byte_mode))
		else $error("width select not following request");
endmodule
`default_nettype wire

/* File: verification/flash_dev_model.sv */
/*
 flash_dev_model: behavioural NOR flash command decoder and array.
 Assumes word mode and a data bus already resolved from both drivers.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model
	import flash_ctrl_pkg::*;
#(
	parameter int          PROG_NS  = 500,
	parameter int          ERASE_NS = 20000,
	parameter logic [15:0] MFR_ID   = 16'h00A3, // arbitrary value
	parameter logic [15:0] DEV_ID   = 16'h0B4C  // arbitrary value
)(
	input  wire logic              ce_n,
	input  wire logic              we_n,
	input  wire logic              oe_n,
	input  wire logic              byte_n,
	input  wire logic [ADDR_W-1:0] a_in,
	input  wire logic [DATA_W-1:0] dq_wr,
	output var  logic [DATA_W-1:0] dq_rd
);
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] last = '0;
	logic [DATA_W-1:0] rd_v;
	logic [DATA_W-1:0] pd;
	logic [ADDR_W-1:0] lat_a;
	logic [8:0]        sect;
	int                step;
	bit                asel, prog, ers, chip, susp, tmo, tog;
	realtime           t_end, t_left, t_pg;
	wire               wr_n = ce_n | we_n;
	wire               rd_n = ce_n | oe_n;

	function automatic logic [DATA_W-1:0] rdm(input logic [ADDR_W-1:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : '1;
	endfunction

	// finish embedded work whose time has run out
	task automatic settle();
		if (prog && !tmo && $realtime >= t_pg)
			prog = 0;
		if (ers && !susp && $realtime >= t_end) begin
			if (chip)
				mem.delete();
			else
				foreach (mem[k])
					if (k[20:12] == sect)
						mem[k] = '1;
			ers = 0;
			chip = 0;
		end
	endtask

	task automatic decode(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic u1;
		logic [DATA_W-1:0] msk;
		u1 = a == UNLOCK_ADDR1;
		case (step)
			0, 3: step = (u1 && d[7:0] == UNLOCK_DATA1) ? step + 1 : 0;
			1, 4: step = (a == UNLOCK_ADDR2 && d[7:0] == UNLOCK_DATA2) ? step + 1 : 0;
			2: begin
				step = 0;
				if (u1 && d[7:0] == CMD_PROGRAM)
					step = 6;
				if (u1 && d[7:0] == CMD_ERASE_SET && !susp)
					step = 3;
				if (u1 && d[7:0] == CMD_AUTOSEL && !susp)
					asel = 1;
			end
			5: begin
				step = 0;
				ers = d[7:0] == CMD_SECT_ERS || (u1 && d[7:0] == CMD_CHIP_ERS);
				chip = ers && d[7:0] == CMD_CHIP_ERS;
				sect = a[20:12];
				t_end = $realtime + ERASE_NS;
			end
			6: begin
				step = 0;
				msk = byte_n ? '1 : 16'h00FF;
				pd = rdm(a);
				tmo = |(~pd & d & msk);
				mem[int'(a)] = pd & (d | ~msk);
				pd = d;
				prog = 1;
				t_pg = $realtime + PROG_NS;
			end
			default: step = 0;
		endcase
	endtask

	always @(negedge wr_n)
		lat_a = a_in;

	always @(posedge wr_n) begin
		settle();
		if (tmo && dq_wr[7:0] == CMD_RESET) begin
			tmo = 0;
			prog = 0;
		end else if (prog || (ers && !susp)) begin
			if (ers && !chip && !prog && dq_wr[7:0] == CMD_SUSPEND) begin
				susp = 1;
				t_left = t_end - $realtime;
			end
		end else if (dq_wr[7:0] == CMD_RESET) begin
			step = 0;
			asel = 0;
		end else if (susp && step == 0 && dq_wr[7:0] == CMD_SECT_ERS) begin
			susp = 0;
			t_end = $realtime + t_left;
		end else
			decode(lat_a, dq_wr);
	end

	always @(negedge rd_n) begin
		settle();
		tog = ~tog;
	end

	// released bus shows the inverse of the last driven value
	always @(*) begin
		if (prog || (ers && !susp))
			rd_v = {8'h00, prog ? ~pd[7] : 1'b0, tog, tmo, 5'h00};
		else if (susp && a_in[20:12] == sect)
			rd_v = {8'h00, 5'h10, tog, 2'h0};
		else if (asel)
			rd_v = a_in[7:0] == 8'h00 ? MFR_ID : (a_in[7:0] == 8'h01 ? DEV_ID : '0);
		else
			rd_v = rdm(a_in);
		dq_rd = rd_n ? ~last : rd_v;
	end

	always @(posedge rd_n)
		last = rd_v;
endmodule
`default_nettype wire

/* File: verification/flash_command_state_machine_test.sv */
/*
 flash_command_state_machine_test: drives user operations into the host
 controller against the flash model. Assumes a 200 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_command_state_machine_test;
	import flash_ctrl_pkg::*;
	localparam int          LIMIT = 30000;
	localparam int          ERS   = 20000;
	localparam logic [15:0] MID   = 16'h00A3; // arbitrary value
	localparam logic [15:0] DID   = 16'h0B4C; // arbitrary value
	logic              sys_clk, rst_n, req, byte_mode, busy, ack, fail, suspended;
	logic              ce_n, we_n, oe_n, byte_n, dq_oe, got_fail;
	logic [3:0]        op;
	logic [ADDR_W-1:0] req_addr, a_out;
	logic [DATA_W-1:0] req_data, dq_out, rd_data, dev_dq, bus, got_data;
	int                mismatches, tests_run, cycles, n;

	assign bus = dq_oe ? dq_out : dev_dq;

	flash_cmd_host #(.SUSPEND_WAIT(10)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .op(op),
		.req_addr(req_addr), .req_data(req_data), .byte_mode(byte_mode), .dq_in(bus), .busy(busy),
		.ack(ack), .fail(fail), .rd_data(rd_data), .suspended(suspended), .ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .byte_n(byte_n), .a_out(a_out), .dq_out(dq_out), .dq_oe(dq_oe));

	flash_dev_model #(.ERASE_NS(ERS), .MFR_ID(MID), .DEV_ID(DID)) dev (.ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .byte_n(byte_n), .a_in(a_out), .dq_wr(bus), .dq_rd(dev_dq));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic results();
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			results();
		end
	end

	task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// wait idle, present one request for one taking edge
	task automatic take(input logic [3:0] o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge sys_clk);
		while (busy !== 1'b0)
			@(negedge sys_clk);
		op = o;
		req_addr = a;
		req_data = d;
		req = 1'b1;
		@(negedge sys_clk);
		req = 1'b0;
	endtask

	task automatic run_op(input logic [3:0] o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		take(o, a, d);
		while (ack !== 1'b1)
			@(negedge sys_clk);
		got_fail = fail;
		got_data = rd_data;
	endtask

	task automatic wr(input logic [3:0] o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic e);
		run_op(o, a, d);
		chk_flag(got_fail, e);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		run_op(OP_READ, a, '0);
		chk_data(got_data, e);
	endtask

	initial begin
		rst_n = 1'b0;
		req = 1'b0;
		op = OP_READ;
		req_addr = '0;
		req_data = '0;
		byte_mode = 1'b0;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		chk_flag(ce_n & we_n & oe_n & ~dq_oe & ~busy, 1'b1);
		chk_flag(byte_n, 1'b1);
		rd(21'h100, 16'hFFFF);
		wr(OP_PROGRAM, 21'h100, 16'h1234, 1'b0);
		rd(21'h100, 16'h1234);
		wr(OP_PROGRAM, 21'h100, 16'h1235, 1'b1);
		rd(21'h100, 16'h1234);
		wr(OP_AUTOSEL, 21'h0, 16'h0, 1'b0);
		rd(21'h0, MID);
		rd(21'h1, DID);
		rd(21'h0, MID);
		wr(OP_RESET, 21'h0, 16'h0, 1'b0);
		rd(21'h100, 16'h1234);
		wr(OP_CHIP_ERS, 21'h0, 16'h0, 1'b0);
		rd(21'h100, 16'hFFFF);
		wr(OP_PROGRAM, 21'h1000, 16'h5A5A, 1'b0);
		wr(OP_PROGRAM, 21'h2000, 16'hA5A5, 1'b0);
		take(OP_SECT_ERS, 21'h1234, 16'h0);
		repeat (300) @(negedge sys_clk);
		op = OP_SUSPEND;
		req = 1'b1;
		n = 0;
		while ((busy !== 1'b0 || suspended !== 1'b1) && n < 9000) begin
			@(negedge sys_clk);
			n++;
		end
		req = 1'b0;
		chk_flag(suspended, 1'b1);
		run_op(OP_READ, 21'h1004, '0);
		chk_data(got_data & 16'hFFFB, 16'h0080);
		rd(21'h2000, 16'hA5A5);
		wr(OP_PROGRAM, 21'h3000, 16'h0F0F, 1'b0);
		rd(21'h3000, 16'h0F0F);
		wr(OP_AUTOSEL, 21'h0, 16'h0, 1'b1);
		wr(OP_SUSPEND, 21'h0, 16'h0, 1'b1);
		run_op(OP_RESUME, 21'h0, 16'h0);
		chk_flag(suspended, 1'b0);
		repeat (ERS / 5) @(negedge sys_clk);
		rd(21'h1000, 16'hFFFF);
		rd(21'h2000, 16'hA5A5);
		wr(OP_RESUME, 21'h0, 16'h0, 1'b1);
		wr(OP_SUSPEND, 21'h0, 16'h0, 1'b1);
		byte_mode = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk_flag(byte_n, 1'b0);
		results();
	end
endmodule
`default_nettype wire
